// file: verilog/mcg_pkg.sv
/*
 * Constants for the master clock generator: register map, field layout,
 * reset values, mode codes and loop tuning figures.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package mcg_pkg;

   // ==========================================================================
   // Register map (byte addresses)
   localparam logic [11:0] MCG_CFG_OFFSET = 12'h000;
   localparam logic [11:0] MCG_SYS1_OFFSET = 12'h004;
   localparam logic [11:0] MCG_STATUS_OFFSET = 12'h008;

   // ==========================================================================
   // Clock configuration register fields
   localparam int MCG_SEL_LSB = 0;
   localparam int MCG_SEL_W = 2;
   localparam int MCG_IDIV_LSB = 4;
   localparam int MCG_IDIV_W = 2;
   localparam int MCG_ODIV_LSB = 8;
   localparam int MCG_ODIV_W = 4;
   localparam int MCG_MUL_LSB = 16;
   localparam int MCG_MUL_W = 8;

   // Largest usable settings of the two prescalers
   localparam logic [MCG_IDIV_W-1:0] MCG_IDIV_MAX = 2'h3;
   localparam logic [MCG_ODIV_W-1:0] MCG_ODIV_MAX = 4'hE;

   // ==========================================================================
   // System configuration one register and status register fields
   localparam int MCG_HALVE_BIT = 0;
   localparam int MCG_STAT_LOCK_BIT = 0;
   localparam int MCG_STAT_LOOP_BIT = 1;
   localparam int MCG_STAT_MODE_LSB = 4;

   // ==========================================================================
   // Reset values: bypass, both prescalers at one
   localparam logic [MCG_SEL_W-1:0] MCG_SEL_RESET = 2'h0;
   localparam logic [MCG_IDIV_W-1:0] MCG_IDIV_RESET = 2'h0;
   localparam logic [MCG_ODIV_W-1:0] MCG_ODIV_RESET = 4'h0;
   localparam logic [MCG_MUL_W-1:0] MCG_MUL_RESET = 8'h00;
   localparam logic MCG_HALVE_RESET = 1'b0;

   // ==========================================================================
   // Source select codes; the low bit is ignored unless the high bit is set
   typedef enum logic [1:0]
   {
      MCG_MODE_BYPASS = 2'b00,
      MCG_MODE_BYPASS_ALT = 2'b01,
      MCG_MODE_PRESCALE = 2'b10,
      MCG_MODE_LOOP = 2'b11
   } mcg_mode_e;

   // ==========================================================================
   // Digital loop tuning
   localparam int MCG_ACC_W = 24;
   localparam logic [MCG_ACC_W-1:0] MCG_INC_RESET = 24'h100000;
   localparam logic [MCG_ACC_W-1:0] MCG_INC_STEP = 24'h000400;
   localparam int MCG_LOCK_RUNS = 8;

endpackage

// file: verilog/mcg_nco.sv
/*
 * Numerically controlled oscillator and frequency-tracking loop.
 * Assumes ref_tick pulses once per reference half period and that
 * the target count is stable while the loop runs.
 */
`timescale 1ns/100ps
`default_nettype none

module mcg_nco #(
   parameter int ACC_W = mcg_pkg::MCG_ACC_W,
   parameter int CNT_W = mcg_pkg::MCG_MUL_W + 1,
   parameter int LOCK_RUNS = mcg_pkg::MCG_LOCK_RUNS
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Loop control
   input wire logic enable,
   input wire logic ref_tick,
   input wire logic [CNT_W-1:0] target,
   // Loop outputs
   output logic vco_toggle,
   output logic locked
);
   import mcg_pkg::*;

   logic [ACC_W-1:0] acc_reg, acc_next;
   logic [ACC_W-1:0] inc_reg, inc_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [3:0] run_reg, run_next;
   logic toggle_reg, toggle_next;
   logic locked_reg, locked_next;
   logic [ACC_W-1:0] acc_sum;

   // ==========================================================================
   // Next state
   always_comb
   begin
      acc_sum = acc_reg + inc_reg;
      acc_next = enable ? acc_sum : acc_reg;
      toggle_next = enable && (acc_sum[ACC_W-1] != acc_reg[ACC_W-1]);
      inc_next = inc_reg;
      cnt_next = cnt_reg;
      run_next = run_reg;
      locked_next = locked_reg;
      if (!enable)
      begin
         cnt_next = '0;
         run_next = '0;
         locked_next = 1'b0;
      end
      else if (ref_tick)
      begin
         // One step per reference tick keeps frequency changes gradual
         cnt_next = CNT_W'(toggle_next);
         if (cnt_reg < target && inc_reg <= ~MCG_INC_STEP)
            inc_next = inc_reg + MCG_INC_STEP;
         else if (cnt_reg > target && inc_reg > MCG_INC_STEP)
            inc_next = inc_reg - MCG_INC_STEP;
         if (cnt_reg == target)
         begin
            if (run_reg != 4'(LOCK_RUNS))
               run_next = run_reg + 4'h1;
         end
         else
            run_next = '0;
         locked_next = (run_next == 4'(LOCK_RUNS));
      end
      else if (toggle_next && cnt_reg != {CNT_W{1'b1}})
         cnt_next = cnt_reg + CNT_W'(1);
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_reg <= '0;
         inc_reg <= MCG_INC_RESET;
         cnt_reg <= '0;
         run_reg <= '0;
         toggle_reg <= 1'b0;
         locked_reg <= 1'b0;
      end
      else
      begin
         acc_reg <= acc_next;
         inc_reg <= inc_next;
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         toggle_reg <= toggle_next;
         locked_reg <= locked_next;
      end
   end

   assign vco_toggle = toggle_reg;
   assign locked = locked_reg;

endmodule

`default_nettype wire

// file: verilog/mcg_master_clock.sv
/*
 * Master clock generator with APB register access.
 * Assumes the oscillator input is synchronous to pclk and toggles at most
 * once per pclk cycle; all generated clocks are sampled levels on pclk.
 */
// Overview of operation
// - Select code 0x divides oscillator by input times output prescale values.
// - Both prescalers zero in bypass: master clock copies oscillator high/low.
// - Input prescale up to 3, output up to 14, slowest divide 60.
// - Select code 11 runs loop: oscillator times multiply over both prescales.
// - Loop keeps tracking oscillator, changing frequency gradually, never abruptly.
// - One writable configuration register selects bypass, prescaler or loop.
// - CPU clock equals master or half; peripheral clock equals CPU clock.
`timescale 1ns/100ps
`default_nettype none

module mcg_master_clock #(
   parameter int MUL_W = mcg_pkg::MCG_MUL_W,
   parameter int LOCK_RUNS = mcg_pkg::MCG_LOCK_RUNS
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Oscillator
   input wire logic oscillator_input_pin,
   // Generated clocks and status
   output logic master_clock,
   output logic cpu_clock,
   output logic peripheral_system_clock,
   output logic pll_locked
);
   import mcg_pkg::*;

   // ==========================================================================
   // Decoding helpers
   function automatic logic is_loop(input logic [MCG_SEL_W-1:0] sel);
      is_loop = (mcg_mode_e'(sel) == MCG_MODE_LOOP);
   endfunction

   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = (addr == MCG_CFG_OFFSET) || (addr == MCG_SYS1_OFFSET) ||
                  (addr == MCG_STATUS_OFFSET);
   endfunction

   // ==========================================================================
   // Declarations
   logic [MCG_SEL_W-1:0] sel_reg, sel_next;
   logic [MCG_IDIV_W-1:0] idiv_reg, idiv_next;
   logic [MCG_ODIV_W-1:0] odiv_reg, odiv_next;
   logic [MUL_W-1:0] mul_reg, mul_next;
   logic halve_reg, halve_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic osc_prev_reg;
   logic [MCG_IDIV_W-1:0] in_cnt_reg, in_cnt_next;
   logic [MCG_ODIV_W-1:0] out_cnt_reg, out_cnt_next;
   logic master_reg, master_next;
   logic cpu_reg, cpu_next;
   logic sys_reg;
   logic locked_reg;
   logic osc_edge;
   logic ref_tick;
   logic src_event;
   logic vco_toggle;
   logic nco_locked;
   logic loop_on;
   logic commit;
   logic [MCG_ODIV_W-1:0] odiv_wr;
   logic [31:0] cfg_view;
   logic [31:0] sys1_view;
   logic [31:0] status_view;

   // ==========================================================================
   // Register views
   always_comb
   begin
      cfg_view = '0;
      cfg_view[MCG_SEL_LSB +: MCG_SEL_W] = sel_reg;
      cfg_view[MCG_IDIV_LSB +: MCG_IDIV_W] = idiv_reg;
      cfg_view[MCG_ODIV_LSB +: MCG_ODIV_W] = odiv_reg;
      cfg_view[MCG_MUL_LSB +: MUL_W] = mul_reg;
      sys1_view = '0;
      sys1_view[MCG_HALVE_BIT] = halve_reg;
      status_view = '0;
      status_view[MCG_STAT_LOCK_BIT] = locked_reg;
      status_view[MCG_STAT_LOOP_BIT] = loop_on;
      status_view[MCG_STAT_MODE_LSB +: MCG_SEL_W] = sel_reg;
   end

   // ==========================================================================
   // APB slave: one wait state, answer registered
   assign commit = psel && penable && pready_reg;
   assign odiv_wr = pwdata[MCG_ODIV_LSB +: MCG_ODIV_W];

   always_comb
   begin
      pready_next = psel && penable && !pready_reg;
      pslverr_next = pready_next && !is_mapped(paddr);
      prdata_next = prdata_reg;
      if (pready_next)
      begin
         if (pwrite || !is_mapped(paddr))
            prdata_next = '0;
         else if (paddr == MCG_CFG_OFFSET)
            prdata_next = cfg_view;
         else if (paddr == MCG_SYS1_OFFSET)
            prdata_next = sys1_view;
         else
            prdata_next = status_view;
      end
      sel_next = sel_reg;
      idiv_next = idiv_reg;
      odiv_next = odiv_reg;
      mul_next = mul_reg;
      halve_next = halve_reg;
      if (commit && pwrite && paddr == MCG_CFG_OFFSET)
      begin
         // A single register picks the mechanism and every factor but the CPU halving
         sel_next = pwdata[MCG_SEL_LSB +: MCG_SEL_W];
         idiv_next = pwdata[MCG_IDIV_LSB +: MCG_IDIV_W];
         // Output prescale saturates at its largest legal setting
         odiv_next = (odiv_wr > MCG_ODIV_MAX) ? MCG_ODIV_MAX : odiv_wr;
         mul_next = pwdata[MCG_MUL_LSB +: MUL_W];
      end
      if (commit && pwrite && paddr == MCG_SYS1_OFFSET)
         halve_next = pwdata[MCG_HALVE_BIT];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
         sel_reg <= MCG_SEL_RESET;
         idiv_reg <= MCG_IDIV_RESET;
         odiv_reg <= MCG_ODIV_RESET;
         mul_reg <= MCG_MUL_RESET;
         halve_reg <= MCG_HALVE_RESET;
      end
      else
      begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         sel_reg <= sel_next;
         idiv_reg <= idiv_next;
         odiv_reg <= odiv_next;
         mul_reg <= mul_next;
         halve_reg <= halve_next;
      end
   end

   // ==========================================================================
   // Input prescaler: counts oscillator half periods
   // Counting both edges lets a divide of one reproduce the input duty cycle.
   assign osc_edge = oscillator_input_pin ^ osc_prev_reg;
   assign loop_on = is_loop(sel_reg);

   always_comb
   begin
      ref_tick = 1'b0;
      in_cnt_next = in_cnt_reg;
      if (osc_edge)
      begin
         if (in_cnt_reg >= idiv_reg)
         begin
            in_cnt_next = '0;
            ref_tick = 1'b1;
         end
         else
            in_cnt_next = in_cnt_reg + 1'b1;
      end
   end

   // ==========================================================================
   // Loop oscillator: tracks the prescaled reference
   mcg_nco #(
      .ACC_W(MCG_ACC_W),
      .CNT_W(MUL_W + 1),
      .LOCK_RUNS(LOCK_RUNS)
   ) u_nco (
      .pclk(pclk),
      .presetn(presetn),
      .enable(loop_on),
      .ref_tick(ref_tick),
      .target({1'b0, mul_reg} + (MUL_W + 1)'(1)),
      .vco_toggle(vco_toggle),
      .locked(nco_locked)
   );

   // ==========================================================================
   // Output prescaler and derived clocks
   always_comb
   begin
      // Bypass and prescale take reference ticks, the loop its own toggles
      src_event = loop_on ? vco_toggle : ref_tick;
      out_cnt_next = out_cnt_reg;
      master_next = master_reg;
      if (src_event)
      begin
         if (out_cnt_reg >= odiv_reg)
         begin
            out_cnt_next = '0;
            // Outside loop mode, with both factors one, each oscillator edge flips the output
            master_next = !master_reg;
         end
         else
            out_cnt_next = out_cnt_reg + 1'b1;
      end
      if (halve_reg)
         cpu_next = (master_next && !master_reg) ? !cpu_reg : cpu_reg;
      else
         cpu_next = master_next;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_prev_reg <= 1'b0;
         in_cnt_reg <= '0;
         out_cnt_reg <= '0;
         master_reg <= 1'b0;
         cpu_reg <= 1'b0;
         sys_reg <= 1'b0;
         locked_reg <= 1'b0;
      end
      else
      begin
         osc_prev_reg <= oscillator_input_pin;
         in_cnt_reg <= in_cnt_next;
         out_cnt_reg <= out_cnt_next;
         master_reg <= master_next;
         cpu_reg <= cpu_next;
         sys_reg <= cpu_next;
         locked_reg <= nco_locked && loop_on;
      end
   end

   // ==========================================================================
   // Outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign master_clock = master_reg;
   assign cpu_clock = cpu_reg;
   assign peripheral_system_clock = sys_reg;
   assign pll_locked = locked_reg;

endmodule

`default_nettype wire

// file: test/mcg_osc_model.sv
/* Oscillator source model: a free-running clock level.
   Assumes pclk is the bench clock; the level moves only after its edges. */
`timescale 1ns/100ps
`default_nettype none
module mcg_osc_model
(
   // Clock
   input wire logic pclk,
   // Half period in pclk cycles, at least 1
   input wire logic [7:0] half_cycles,
   // Oscillator level
   output logic osc
);
   logic [7:0] cnt_reg;
   // ====
   // Level keeps each value for at least one pclk
   initial
   begin
      osc = 1'b0;
      cnt_reg = 8'h00;
   end
   always @(posedge pclk)
   begin
      if (cnt_reg + 8'h01 >= half_cycles)
      begin
         cnt_reg <= 8'h00;
         osc <= ~osc;
      end
      else
         cnt_reg <= cnt_reg + 8'h01;
   end
endmodule
`default_nettype wire

// file: test/mcg_master_clock_properties.sv
/* Port checker for the master clock generator.
   Assumes config changes only by APB writes seen at these ports. */
`timescale 1ns/100ps
`default_nettype none
module mcg_master_clock_properties
   import mcg_pkg::*;
#(
   parameter int MUL_W = 8,
   parameter int LOCK_RUNS = 8
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Clocks
   input wire logic oscillator_input_pin,
   input wire logic master_clock,
   input wire logic cpu_clock,
   input wire logic peripheral_system_clock,
   input wire logic pll_locked
);
   logic hs;
   logic mapped;
   logic [1:0] sel_reg;
   logic halve_reg;
   logic [1:0] quiet_reg;
   // ====
   // Snooped config; quiet guards the cycles right after a write
   assign hs = psel && penable && pready;
   assign mapped = paddr == MCG_CFG_OFFSET || paddr == MCG_SYS1_OFFSET
      || paddr == MCG_STATUS_OFFSET;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_reg <= 2'h0;
         halve_reg <= 1'b0;
         quiet_reg <= 2'h0;
      end
      else
      begin
         if (hs && pwrite && paddr == MCG_CFG_OFFSET)
            sel_reg <= pwdata[1:0];
         if (hs && pwrite && paddr == MCG_SYS1_OFFSET)
            halve_reg <= pwdata[0];
         quiet_reg <= (hs && pwrite) ? 2'h0 : (quiet_reg == 2'h3 ? 2'h3 : quiet_reg + 2'h1);
      end
   end
   // ====
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ready_timing_a: assert property (psel && !penable |-> ##2 (pready && penable))
      else $error("APB answer late or early");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_mapped_a: assert property (hs && mapped |-> !pslverr)
      else $error("error on a mapped register");
   err_unmapped_a: assert property (hs && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   sys_cpu_a: assert property (peripheral_system_clock == cpu_clock)
      else $error("peripheral clock differs from cpu clock");
   bypass_lag_a: assert property (sel_reg != 2'h3 && quiet_reg == 2'h3 && $changed(master_clock)
      |-> $past(oscillator_input_pin) != $past(oscillator_input_pin, 2))
      else $error("bypass master moved without oscillator edge");
   cpu_full_a: assert property (quiet_reg == 2'h3 && !halve_reg |-> cpu_clock == master_clock)
      else $error("cpu clock not equal to master");
   cpu_half_a: assert property (quiet_reg == 2'h3 && halve_reg && $changed(cpu_clock)
      |-> $rose(master_clock))
      else $error("halved cpu clock off master rise");
   lock_mode_a: assert property (quiet_reg == 2'h3 && pll_locked |-> sel_reg == 2'h3)
      else $error("lock flag outside loop mode");
   cover property (hs && pslverr);
   cover property ($rose(pll_locked));
   cover property (halve_reg && $rose(cpu_clock));
endmodule
bind mcg_master_clock mcg_master_clock_properties #(.MUL_W(MUL_W), .LOCK_RUNS(LOCK_RUNS)) chk_u
(
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .oscillator_input_pin(oscillator_input_pin), .master_clock(master_clock),
   .cpu_clock(cpu_clock), .peripheral_system_clock(peripheral_system_clock),
   .pll_locked(pll_locked)
);
`default_nettype wire

// file: test/mcg_master_clock_bench.sv
/* Self-checking bench for the master clock generator.
   Assumes the oscillator model and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none
module mcg_master_clock_bench;
   import mcg_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic osc, mclk, cclk, sclk, lock;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, wd;
   logic [7:0] half;
   int err_total, n_tests, cyc, p, n;
   logic [1:0] sl[3] = '{2'h0, 2'h1, 2'h2};
   logic [1:0] id[3] = '{2'h0, 2'h1, 2'h3};
   logic [3:0] od[3] = '{4'h0, 4'h2, 4'hE};
   int hv[3] = '{3, 2, 1};
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;
   mcg_master_clock #(.MUL_W(8), .LOCK_RUNS(2)) dut_u
   (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .oscillator_input_pin(osc), .master_clock(mclk), .cpu_clock(cclk),
      .peripheral_system_clock(sclk), .pll_locked(lock)
   );
   mcg_osc_model osc_u (.pclk(pclk), .half_cycles(half), .osc(osc));
   // ====
   // Tasks
   task test_done;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL %0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_per(input int got, input int exp, input int tol);
      n_tests++;
      if (got > exp + tol || got < exp - tol)
      begin
         err_total++;
         $display("FAIL %0t period got %0d exp %0d", $time, got, exp);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // Look between edges so the value seen is the one the next edge samples
      @(negedge pclk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(negedge pclk);
         k++;
      end
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Cycles between the second and third rise; the first is settling
   task period(input logic s, output int q);
      int e;
      int k;
      logic prv;
      logic cur;
      e = 0;
      k = 0;
      q = 0;
      prv = 1'b1;
      while (e < 3 && k < 1000)
      begin
         @(negedge pclk);
         cur = s ? cclk : mclk;
         k++;
         if (e == 2)
            q++;
         if (cur === 1'b1 && prv === 1'b0)
            e++;
         prv = cur;
      end
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 40000)
      begin
         err_total++;
         $display("FAIL %0t timeout", $time);
         test_done;
      end
   end
   // ====
   // Tests
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      half = 8'h03;
      {err_total, n_tests, cyc} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(MCG_CFG_OFFSET, 1'b0, 32'h0);
      chk_reg(rd, 32'h0);
      apb(MCG_SYS1_OFFSET, 1'b0, 32'h0);
      chk_reg(rd, 32'h0);
      apb(MCG_STATUS_OFFSET, 1'b1, 32'hFFFFFFFF);
      apb(MCG_STATUS_OFFSET, 1'b0, 32'h0);
      chk_reg(rd, 32'h0);
      apb(12'h00C, 1'b0, 32'h0);
      chk_reg({er, rd[30:0]}, 32'h80000000);
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         half <= 8'(hv[i]);
         wd = {16'h0000, 4'h0, od[i], 2'h0, id[i], 2'h0, sl[i]};
         apb(MCG_CFG_OFFSET, 1'b1, wd);
         apb(MCG_CFG_OFFSET, 1'b0, 32'h0);
         chk_reg(rd, wd);
         period(1'b0, p);
         chk_per(p, 2 * (int'(id[i]) + 1) * (int'(od[i]) + 1) * hv[i], 0);
      end
      apb(MCG_CFG_OFFSET, 1'b1, 32'h00000F00);
      apb(MCG_CFG_OFFSET, 1'b0, 32'h0);
      chk_reg(rd, 32'h00000E00);
      $display("test bypass done");
      half <= 8'h02;
      apb(MCG_CFG_OFFSET, 1'b1, 32'h0);
      apb(MCG_SYS1_OFFSET, 1'b1, 32'h1);
      period(1'b1, p);
      chk_per(p, 8, 0);
      apb(MCG_SYS1_OFFSET, 1'b1, 32'h0);
      period(1'b1, p);
      chk_per(p, 4, 0);
      $display("test halving done");
      // Reference tick every 256 cycles, 32 loop toggles each, output divide 4
      half <= 8'h80;
      apb(MCG_CFG_OFFSET, 1'b1, 32'h001F0313);
      n = 0;
      while (lock !== 1'b1 && n < 5000)
      begin
         @(posedge pclk);
         n++;
      end
      apb(MCG_STATUS_OFFSET, 1'b0, 32'h0);
      chk_reg(rd, 32'h00000033);
      repeat (2)
      begin
         period(1'b0, p);
         chk_per(p, 64, 1);
      end
      $display("test loop done");
      test_done;
   end
endmodule
`default_nettype wire
